/* dv/ctsa_asserts.sv */
// Checker of answers and settings of the command block
`timescale 1ns/1ps
`default_nettype none
module ctsa_asserts
	import ctsa_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic cmd_valid_in,
	input wire ctsa_cmd_t cmd_in,
	input wire logic trigger_pin_in,
	input wire logic ans_valid_out,
	input wire logic [1:0] ans_code_out,
	input wire ctsa_window_t window_out,
	input wire logic trigger_active_level_out,
	input wire logic trigger_asserted_out,
	input wire logic trigger_start_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Cycles since reset, until the pin pipeline has filled
	logic [1:0] settle;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle <= 2'h0;
		end else if (settle != 2'h3) begin
			settle <= settle + 2'h1;
		end
	end
	AST_TRIG_LEVEL: assert property (settle == 2'h3 |-> trigger_asserted_out ==
		($past(trigger_pin_in, 3) ~^ $past(trigger_active_level_out))) else $error("trigger level");
	AST_TRIG_START: assert property (trigger_start_out ==
		(trigger_asserted_out && !$past(trigger_asserted_out))) else $error("trigger start");
	AST_POL: assert property (cmd_valid_in && cmd_in.op == CTSA_OP_POL &&
		(cmd_in.letter == CTSA_CHAR_N || cmd_in.letter == CTSA_CHAR_P) |=>
		trigger_active_level_out == ($past(cmd_in.letter) == CTSA_CHAR_P)) else $error("pol");
	AST_START: assert property (cmd_valid_in && cmd_in.op == CTSA_OP_START &&
		cmd_in.value[2:0] == 3'h0 && cmd_in.value <= CTSA_START_MAX |=> ans_valid_out &&
		window_out.row_start == $past(cmd_in.value)) else $error("row start");
	AST_COUNT: assert property (cmd_valid_in && cmd_in.op == CTSA_OP_COUNT &&
		cmd_in.value[2:0] == 3'h0 && cmd_in.value >= CTSA_COUNT_MIN &&
		cmd_in.value <= CTSA_COUNT_MAX |=> ans_valid_out && ans_code_out == CTSA_ANS_OK &&
		window_out.row_count == $past(cmd_in.value)) else $error("row count");
	AST_ALIGN: assert property (cmd_valid_in && cmd_in.op[1] && cmd_in.value[2:0] != 3'h0
		|=> ans_valid_out && ans_code_out == CTSA_ANS_BAD_PARAM) else $error("align");
	AST_KEEP: assert property (ans_valid_out && ans_code_out != CTSA_ANS_OK
		|-> $stable(window_out)) else $error("window changed");
endmodule
bind ctsa_top ctsa_asserts u_asserts (.clk_in, .rst_n_in, .cmd_valid_in, .cmd_in, .trigger_pin_in,
	.ans_valid_out, .ans_code_out, .window_out, .trigger_active_level_out, .trigger_asserted_out,
	.trigger_start_out);
`default_nettype wire

/* dv/ctsa_host.sv */
// Host model issuing one-cycle setup commands
`timescale 1ns/1ps
`default_nettype none
module ctsa_host
	import ctsa_pkg::*;
(
	// Clock and request from the bench
	input wire logic clk_in,
	input wire logic req_in,
	input wire ctsa_cmd_t req_cmd_in,
	// Command to the block
	output logic cmd_valid_out = 1'h0,
	output ctsa_cmd_t cmd_out = '0
);
	// Changing junk on the command bus between commands
	always @(posedge clk_in) begin
		cmd_valid_out <= req_in;
		cmd_out <= req_in ? req_cmd_in : ~cmd_out;
	end
endmodule
`default_nettype wire

/* dv/ctsa_top_test.sv */
// Self-checking testbench of the command block
`timescale 1ns/1ps
`default_nettype none
module ctsa_top_test;
	import ctsa_pkg::*;
	logic clk_in = 1'h0, rst_n_in = 1'h0, req = 1'h0, pin = 1'h0, cmd_valid, ans_valid, lvl;
	logic [1:0] code;
	ctsa_cmd_t rq = '0, cmd;
	ctsa_window_t win, e_win = '{CTSA_START_RST, CTSA_COUNT_RST};
	logic e_pol = CTSA_POL_RST;
	logic [26:0] q[$];
	logic [11:0] vals[7] = '{12'h000, 12'hA68, 12'hA70, 12'hA78, 12'hA69, 12'h007, 12'h008};
	int failures = 0, n_compared = 0, cyc = 0;
	always #4 clk_in = ~clk_in;
	ctsa_host HOST (.clk_in, .req_in(req), .req_cmd_in(rq), .cmd_valid_out(cmd_valid),
		.cmd_out(cmd));
	ctsa_top DUT (.clk_in, .rst_n_in, .cmd_valid_in(cmd_valid), .cmd_in(cmd),
		.trigger_pin_in(pin), .ans_valid_out(ans_valid), .ans_code_out(code), .window_out(win),
		.trigger_active_level_out(lvl), .trigger_asserted_out(), .trigger_start_out());
	task automatic end_of_test();
		if (failures == 0 && n_compared > 0 && q.size() == 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Notes the expected answer, then issues the command
	task automatic send(input logic [1:0] op, input logic [7:0] l, input logic [11:0] v);
		logic [1:0] c;
		c = CTSA_ANS_OK;
		case (op)
			CTSA_OP_POL: if (l == CTSA_CHAR_N || l == CTSA_CHAR_P) e_pol = l == CTSA_CHAR_P;
				else c = CTSA_ANS_BAD_PARAM;
			CTSA_OP_START: if (v[2:0] != 3'h0) c = CTSA_ANS_BAD_PARAM;
				else if (v > CTSA_START_MAX) c = CTSA_ANS_RANGE; else e_win.row_start = v;
			CTSA_OP_COUNT: if (v[2:0] != 3'h0) c = CTSA_ANS_BAD_PARAM;
				else if (v < CTSA_COUNT_MIN || v > CTSA_COUNT_MAX) c = CTSA_ANS_RANGE;
				else e_win.row_count = v;
			default: c = CTSA_ANS_BAD_CMD;
		endcase
		q.push_back({c, e_win, e_pol});
		req <= 1'h1;
		rq <= '{op, l, v};
		@(posedge clk_in);
	endtask
	// Compares each answer with the oldest note
	always @(posedge clk_in) begin
		pin <= 1'($urandom);
		if (++cyc > 1000) begin
			failures++;
			end_of_test();
		end
		if (ans_valid === 1'h1) begin
			n_compared++;
			if ({code, win, lvl} !== q.pop_front()) begin
				failures++;
				$display("ERROR %0t answer mismatch", $time);
			end
		end
	end
	// Boundary table, then back-to-back random commands
	initial begin
		void'($urandom(32'h9cb6));
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'h1;
		@(posedge clk_in);
		send(CTSA_OP_POL, CTSA_CHAR_N, 12'h000);
		send(CTSA_OP_POL, CTSA_CHAR_P, 12'h000);
		send(CTSA_OP_POL, 8'h51, 12'h000);
		foreach (vals[i]) send(CTSA_OP_START, 8'h00, vals[i]);
		foreach (vals[i]) send(CTSA_OP_COUNT, 8'h00, vals[i]);
		repeat (60) send(2'($urandom), $urandom % 2 ? CTSA_CHAR_N : CTSA_CHAR_P,
			12'($urandom & ($urandom % 2 ? 32'hFF8 : 32'hFFF)));
		req <= 1'h0;
		repeat (4) @(posedge clk_in);
		end_of_test();
	end
endmodule
`default_nettype wire

/* hdl/ctsa_checker.sv */
// Parameter check of one command against its limits
`timescale 1ns/1ps
`default_nettype none
module ctsa_checker
	import ctsa_pkg::*;
(
	// Command
	input wire ctsa_cmd_t cmd_in,
	// Verdict
	output logic [1:0] answer_out
);

	// ----------------------------------------
	// Verdict logic
	// ----------------------------------------
	logic misaligned;
	assign misaligned = |cmd_in.value[CTSA_ALIGN_BITS-1:0];

	// Alignment error takes priority over range error
	always_comb begin
		answer_out = CTSA_ANS_OK;
		unique case (cmd_in.op)
			CTSA_OP_POL: begin
				if (cmd_in.letter != CTSA_CHAR_N && cmd_in.letter != CTSA_CHAR_P) begin
					answer_out = CTSA_ANS_BAD_PARAM;
				end
			end
			CTSA_OP_START: begin
				if (misaligned) begin
					answer_out = CTSA_ANS_BAD_PARAM;
				end else if (cmd_in.value > CTSA_START_MAX) begin
					answer_out = CTSA_ANS_RANGE;
				end
			end
			CTSA_OP_COUNT: begin
				if (misaligned) begin
					answer_out = CTSA_ANS_BAD_PARAM;
				end else if (cmd_in.value < CTSA_COUNT_MIN || cmd_in.value > CTSA_COUNT_MAX) begin
					answer_out = CTSA_ANS_RANGE;
				end
			end
			default: begin
				answer_out = CTSA_ANS_BAD_CMD;
			end
		endcase
	end

endmodule
`default_nettype wire

/* hdl/ctsa_pkg.sv */
// Constants and carrier types for the trigger and sub-array command block
// Function
// - Polarity letter N is active-low, P active-high
// - Row start 0 to 2664, multiple of 8
// - Row count 8 to 2672, multiple of 8
// - Non-multiple of 8 answers bad_parameter_error
package ctsa_pkg;

	// ----------------------------------------
	// Command codes and limits
	// ----------------------------------------
	localparam int CTSA_VAL_W = 12;
	localparam logic [1:0] CTSA_OP_POL = 2'h1;
	localparam logic [1:0] CTSA_OP_START = 2'h2;
	localparam logic [1:0] CTSA_OP_COUNT = 2'h3;
	localparam logic [7:0] CTSA_CHAR_N = 8'h4E;
	localparam logic [7:0] CTSA_CHAR_P = 8'h50;
	localparam logic [CTSA_VAL_W-1:0] CTSA_START_MIN = 12'h000;
	localparam logic [CTSA_VAL_W-1:0] CTSA_START_MAX = 12'hA68;
	localparam logic [CTSA_VAL_W-1:0] CTSA_COUNT_MIN = 12'h008;
	localparam logic [CTSA_VAL_W-1:0] CTSA_COUNT_MAX = 12'hA70;
	localparam int CTSA_ALIGN_BITS = 3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic CTSA_POL_RST = 1'h1;
	localparam logic [CTSA_VAL_W-1:0] CTSA_START_RST = 12'h000;
	localparam logic [CTSA_VAL_W-1:0] CTSA_COUNT_RST = 12'hA70;

	// ----------------------------------------
	// Answer codes
	// ----------------------------------------
	localparam logic [1:0] CTSA_ANS_OK = 2'h0;
	localparam logic [1:0] CTSA_ANS_RANGE = 2'h1;
	localparam logic [1:0] CTSA_ANS_BAD_PARAM = 2'h2;
	localparam logic [1:0] CTSA_ANS_BAD_CMD = 2'h3;

	// Command from the text parser
	typedef struct packed {
		logic [1:0] op;
		logic [7:0] letter;
		logic [CTSA_VAL_W-1:0] value;
	} ctsa_cmd_t;

	// Window setting to the readout sequencer
	typedef struct packed {
		logic [CTSA_VAL_W-1:0] row_start;
		logic [CTSA_VAL_W-1:0] row_count;
	} ctsa_window_t;

endpackage

/* hdl/ctsa_top.sv */
// Trigger polarity and sub-array window command interpreter
`timescale 1ns/1ps
`default_nettype none
module ctsa_top
	import ctsa_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Command from the parser
	input wire logic cmd_valid_in,
	input wire ctsa_cmd_t cmd_in,
	// External trigger pin
	input wire logic trigger_pin_in,
	// Answer to the host
	output logic ans_valid_out,
	output logic [1:0] ans_code_out,
	// Readout sequencer side
	output ctsa_window_t window_out,
	output logic trigger_active_level_out,
	output logic trigger_asserted_out,
	output logic trigger_start_out
);

	// ----------------------------------------
	// Behaviour
	// ----------------------------------------
	// Answer one cycle after a command is taken
	// Misalignment reported ahead of a range error
	// Refused commands leave every setting alone
	// Settings are levels, readable at any time
	// Trigger pin is asynchronous, synchronised first

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Mask of the low bits that must be zero
	localparam logic [CTSA_VAL_W-1:0] CTSA_ALIGN_MASK =
		CTSA_VAL_W'((32'h1 << CTSA_ALIGN_BITS) - 32'h1);

	// Alignment field must lie inside the value
	if (CTSA_ALIGN_BITS < 32'sh1 || CTSA_ALIGN_BITS >= CTSA_VAL_W) begin : g_bad_align
		$error("Alignment field does not fit the value width");
	end

	// Every limit must be an aligned value
	if ((CTSA_START_MIN & CTSA_ALIGN_MASK) != '0 || (CTSA_START_MAX & CTSA_ALIGN_MASK) != '0 ||
		(CTSA_COUNT_MIN & CTSA_ALIGN_MASK) != '0 ||
		(CTSA_COUNT_MAX & CTSA_ALIGN_MASK) != '0) begin : g_bad_limit_align
		$error("Window limits are not aligned");
	end

	// Limits must describe a non-empty range
	if (CTSA_START_MIN > CTSA_START_MAX || CTSA_COUNT_MIN > CTSA_COUNT_MAX) begin : g_bad_order
		$error("Window limits are out of order");
	end

	// A zero-line window cannot be read out
	if (CTSA_COUNT_MIN == '0) begin : g_bad_count_min
		$error("Row count minimum must be above zero");
	end

	// Smallest window at the last start must fit the frame
	if (int'(CTSA_START_MAX) + int'(CTSA_COUNT_MIN) > int'(CTSA_COUNT_MAX)) begin : g_bad_frame
		$error("Last start with smallest count overruns the frame");
	end

	// Reset window must itself pass the range checks
	if (CTSA_START_RST > CTSA_START_MAX || CTSA_COUNT_RST < CTSA_COUNT_MIN ||
		CTSA_COUNT_RST > CTSA_COUNT_MAX) begin : g_bad_reset_window
		$error("Reset window lies outside the limits");
	end

	// Reset window must be aligned like any command
	if ((CTSA_START_RST & CTSA_ALIGN_MASK) != '0 ||
		(CTSA_COUNT_RST & CTSA_ALIGN_MASK) != '0) begin : g_bad_reset_align
		$error("Reset window is not aligned");
	end

	// Clean answer must differ from every refusal
	if (CTSA_ANS_OK == CTSA_ANS_RANGE || CTSA_ANS_OK == CTSA_ANS_BAD_PARAM ||
		CTSA_ANS_OK == CTSA_ANS_BAD_CMD || CTSA_ANS_RANGE == CTSA_ANS_BAD_PARAM ||
		CTSA_ANS_RANGE == CTSA_ANS_BAD_CMD ||
		CTSA_ANS_BAD_PARAM == CTSA_ANS_BAD_CMD) begin : g_bad_answer_codes
		$error("Answer codes are not distinct");
	end

	// Op codes distinct, zero kept for unknown
	if (CTSA_OP_POL == CTSA_OP_START || CTSA_OP_POL == CTSA_OP_COUNT ||
		CTSA_OP_START == CTSA_OP_COUNT || CTSA_OP_POL == '0 || CTSA_OP_START == '0 ||
		CTSA_OP_COUNT == '0) begin : g_bad_op_codes
		$error("Op codes are not distinct");
	end

	// Two polarity letters must differ
	if (CTSA_CHAR_N == CTSA_CHAR_P) begin : g_bad_letters
		$error("Polarity letters are not distinct");
	end

	// ----------------------------------------
	// Checker
	// ----------------------------------------
	// Verdict is combinational on the live command
	logic [1:0] verdict;
	ctsa_checker u_checker (
		.cmd_in(cmd_in),
		.answer_out(verdict)
	);

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	// Only a clean verdict may touch a setting
	logic cmd_clean;
	logic take_pol;
	logic take_start;
	logic take_count;
	logic next_level;
	assign cmd_clean = cmd_valid_in && (verdict == CTSA_ANS_OK);
	assign take_pol = cmd_clean && (cmd_in.op == CTSA_OP_POL);
	assign take_start = cmd_clean && (cmd_in.op == CTSA_OP_START);
	assign take_count = cmd_clean && (cmd_in.op == CTSA_OP_COUNT);

	// Letter P selects active-high, N active-low
	assign next_level = (cmd_in.letter == CTSA_CHAR_P);

	// ----------------------------------------
	// Answer
	// ----------------------------------------
	// One-cycle answer pulse, every command answered
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ans_valid_out <= 1'h0;
		end else begin
			ans_valid_out <= cmd_valid_in;
		end
	end

	// Code holds until the next command
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ans_code_out <= CTSA_ANS_OK;
		end else if (cmd_valid_in) begin
			ans_code_out <= verdict;
		end
	end

	// ----------------------------------------
	// Window settings
	// ----------------------------------------
	// Window takes only values that passed the checks
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			window_out.row_start <= CTSA_START_RST;
			window_out.row_count <= CTSA_COUNT_RST;
		end else begin
			if (take_start) begin
				window_out.row_start <= cmd_in.value;
			end
			if (take_count) begin
				window_out.row_count <= cmd_in.value;
			end
		end
	end

	// ----------------------------------------
	// Trigger polarity
	// ----------------------------------------
	// Level 1 means active-high, reset positive
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trigger_active_level_out <= CTSA_POL_RST;
		end else if (take_pol) begin
			trigger_active_level_out <= next_level;
		end
	end

	// ----------------------------------------
	// Trigger pin
	// ----------------------------------------
	// Two-stage synchroniser, only second stage read
	logic trig_meta;
	logic trig_sync;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trig_meta <= 1'h0;
			trig_sync <= 1'h0;
		end else begin
			trig_meta <= trigger_pin_in;
			trig_sync <= trig_meta;
		end
	end

	// ----------------------------------------
	// Trigger decode
	// ----------------------------------------
	// Pin level under the selected polarity
	logic next_asserted;
	logic next_start;
	assign next_asserted = ~(trig_sync ^ trigger_active_level_out);
	// Start marks the inactive-to-active step only
	assign next_start = next_asserted & ~trigger_asserted_out;

	// Asserted level, polarity change applies at once
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trigger_asserted_out <= 1'h0;
		end else begin
			trigger_asserted_out <= next_asserted;
		end
	end

	// One-cycle start pulse for the sequencer
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trigger_start_out <= 1'h0;
		end else begin
			trigger_start_out <= next_start;
		end
	end

endmodule
`default_nettype wire
